//--- src/rcmix_pkg.sv
// Constants, register map and field layout of the RC pulse mixer.
// Assumes a 250 MHz pclk and an APB master with 32-bit data.
package rcmix_pkg;
  // Timebase: one measurement count per quarter microsecond
  localparam int unsigned CLK_NS       = 4;
  localparam int unsigned RES_NS       = 250;
  localparam int unsigned ACC_W        = 8;
  localparam logic [ACC_W-1:0] TICK_STEP = ACC_W'(CLK_NS);
  localparam logic [ACC_W-1:0] TICK_WRAP = ACC_W'(RES_NS);
  localparam int unsigned TICKS_PER_S  = 1000000000 / RES_NS;
  // Accepted pulse repetition rates
  localparam int unsigned RATE_MIN_HZ  = 10;
  localparam int unsigned RATE_MAX_HZ  = 333;
  localparam int unsigned PERIOD_MAX_TICKS = TICKS_PER_S / RATE_MIN_HZ;
  localparam int unsigned PERIOD_MIN_TICKS = TICKS_PER_S / RATE_MAX_HZ;
  localparam int unsigned PCNT_W       = 20;
  localparam int unsigned W_W          = 16;
  localparam int unsigned SPD_W        = 16;
  localparam int unsigned GAIN_SHIFT   = 8;
  localparam int unsigned SPEED_MAX_DEF = 3200;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_SPEED    = 8'h04;
  localparam logic [7:0] ADDR_CAL0     = 8'h08;
  localparam logic [7:0] ADDR_CAL1     = 8'h0c;
  localparam logic [7:0] ADDR_WLIM     = 8'h10;
  localparam logic [7:0] ADDR_RC0      = 8'h14;
  localparam logic [7:0] ADDR_RC1      = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
  // Control fields
  localparam int unsigned CTRL_W       = 7;
  localparam int unsigned CTRL_RC_BIT  = 0;
  localparam int unsigned CTRL_MIX_LSB = 1;
  localparam int unsigned CTRL_ERRIN_BIT = 3;
  localparam int unsigned CTRL_KILL_LSB = 4;
  localparam int unsigned CTRL_STOP_BIT = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h08;
  localparam logic [1:0] MIX_OFF       = 2'h0;
  localparam logic [1:0] MIX_LEFT      = 2'h1;
  localparam logic [1:0] MIX_RIGHT     = 2'h2;
  // Calibration word: neutral in [15:0], gain in [31:16]
  localparam logic [31:0] CAL_RST      = 32'h019a_1770;
  // Width limits: minimum in [15:0], maximum in [31:16]
  localparam logic [31:0] WLIM_RST     = 32'h2260_0c80;
  // Status and readback bit positions
  localparam int unsigned RC_VALID_BIT = 16;
  localparam int unsigned ST_STOP_BIT  = 16;
  localparam int unsigned ST_OWN_BIT   = 17;
  localparam int unsigned ST_LINE_BIT  = 18;
  // Interrupt bits
  localparam int unsigned IRQ_W        = 5;
  localparam int unsigned IRQ_NEW_LSB  = 0;
  localparam int unsigned IRQ_BAD_LSB  = 2;
  localparam int unsigned IRQ_STOP_BIT = 4;
endpackage

//--- src/rcmix_core.sv
// RC pulse measurement, throttle/steering mixing and shared error line.
// Assumes an APB master on pclk and asynchronous RC and error line pins.
`timescale 1ns/1ns
module rcmix_core
  import rcmix_pkg::*;
#(
  parameter logic [SPD_W-1:0]  SPEED_MAX  = SPD_W'(SPEED_MAX_DEF),
  parameter logic [PCNT_W-1:0] PERIOD_MIN = PCNT_W'(PERIOD_MIN_TICKS),
  parameter logic [PCNT_W-1:0] PERIOD_MAX = PCNT_W'(PERIOD_MAX_TICKS)
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              throttle_channel_in,
  input  wire logic              steering_channel_in,
  input  wire logic              err_line_in,
  output logic                   err_line_out,
  output logic                   err_line_oe,
  output logic                   err_led,
  output logic signed [SPD_W-1:0] motor_speed,
  output logic                   motor_stop,
  output logic                   irq
);

  typedef struct packed {
    logic [1:0][2:0]        rc_sync;
    logic [1:0]             rc_lvl;
    logic [ACC_W-1:0]       acc;
    logic                   tick;
    logic [1:0][W_W-1:0]    wcnt;
    logic [1:0][PCNT_W-1:0] pcnt;
    logic [1:0]             pok;
    logic [1:0][W_W-1:0]    width;
    logic [1:0]             valid;
    logic [2:0]             err_sync;
    logic                   line;
    logic [CTRL_W-1:0]      ctrl;
    logic [SPD_W-1:0]       ser_speed;
    logic [1:0][31:0]       cal;
    logic [31:0]            wlim;
    logic [IRQ_W-1:0]       irq_stat;
    logic [IRQ_W-1:0]       irq_mask;
    logic                   pready;
    logic [31:0]            prdata;
    logic                   pslverr;
    logic signed [SPD_W-1:0] speed;
    logic                   stop;
    logic                   own_err;
    logic                   err_oe;
    logic                   err_out;
    logic [3:0]             oe_hist;
    logic                   led;
    logic                   irq;
  } rcmix_state_t;

  localparam rcmix_state_t ST_RST = '{ctrl: CTRL_RST, cal: {CAL_RST, CAL_RST}, wlim: WLIM_RST, default: '0};

  rcmix_state_t s_reg;
  rcmix_state_t s_next;

  // Clamp a wide signed value to the symmetric speed limit
  function automatic logic signed [SPD_W-1:0] rcmix_sat(input logic signed [35:0] x);
    logic signed [35:0] lim;
    lim = $signed({20'h0, SPEED_MAX});
    if (x > lim) begin
      return $signed(SPEED_MAX);
    end else if (x < -lim) begin
      return -$signed(SPEED_MAX);
    end
    return x[SPD_W-1:0];
  endfunction

  // Width minus neutral, scaled by gain, saturated
  function automatic logic signed [SPD_W-1:0] rcmix_cal(input logic [W_W-1:0] w, input logic [31:0] c);
    logic signed [16:0] d;
    logic signed [35:0] p;
    d = $signed({1'b0, w}) - $signed({1'b0, c[15:0]});
    p = 36'(d) * 36'($signed({1'b0, c[31:16]}));
    return rcmix_sat(p >>> GAIN_SHIFT);
  endfunction

  // Byte-lane merge for APB4 strobes
  function automatic logic [31:0] rcmix_wm(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [1:0]              rc_pin;
  logic [1:0]              new_ev;
  logic [1:0]              bad_ev;
  logic [1:0]              rise;
  logic [1:0]              fall;
  logic [1:0]              kill_use;
  logic signed [SPD_W-1:0] v0;
  logic signed [SPD_W-1:0] v1;
  logic signed [SPD_W-1:0] spd;
  logic [1:0]              mix;
  logic                    rc_mode;
  logic                    used_bad;
  logic                    kill;
  logic                    own;
  logic                    ext;
  logic                    setup;
  logic                    wr;
  logic                    hit;
  logic [31:0]             rd;
  logic [IRQ_W-1:0]        clr;

  assign rc_pin = {steering_channel_in, throttle_channel_in};

  always_comb begin
    s_next   = s_reg;
    new_ev   = '0;
    bad_ev   = '0;
    rise     = '0;
    fall     = '0;
    kill_use = '0;
    rd       = '0;
    hit      = 1'b1;
    clr      = '0;
    mix      = s_reg.ctrl[CTRL_MIX_LSB +: 2];
    rc_mode  = s_reg.ctrl[CTRL_RC_BIT];

    // Fractional accumulator: 62.5 cycles per count on average
    if (s_reg.acc + TICK_STEP >= TICK_WRAP) begin
      s_next.acc  = s_reg.acc + TICK_STEP - TICK_WRAP;
      s_next.tick = 1'b1;
    end else begin
      s_next.acc  = s_reg.acc + TICK_STEP;
      s_next.tick = 1'b0;
    end

    // Measurement runs regardless of mode
    for (int c = 0; c < 2; c++) begin
      s_next.rc_sync[c] = {s_reg.rc_sync[c][1:0], rc_pin[c]};
      if (s_reg.rc_sync[c][2] == s_reg.rc_sync[c][1]) begin
        s_next.rc_lvl[c] = s_reg.rc_sync[c][2];
      end
      rise[c] = ~s_reg.rc_lvl[c] & s_next.rc_lvl[c];
      fall[c] = s_reg.rc_lvl[c] & ~s_next.rc_lvl[c];
      if (s_reg.tick) begin
        if (s_reg.wcnt[c] != '1) begin
          s_next.wcnt[c] = s_reg.wcnt[c] + 1'b1;
        end
        if (s_reg.pcnt[c] != '1) begin
          s_next.pcnt[c] = s_reg.pcnt[c] + 1'b1;
        end
      end
      // Too slow a pulse train drops validity at once
      if (s_reg.pcnt[c] > PERIOD_MAX) begin
        s_next.pok[c]   = 1'b0;
        s_next.valid[c] = 1'b0;
      end
      if (rise[c]) begin
        s_next.pok[c]  = (s_reg.pcnt[c] >= PERIOD_MIN) && (s_reg.pcnt[c] <= PERIOD_MAX);
        s_next.pcnt[c] = '0;
        s_next.wcnt[c] = '0;
      end
      if (fall[c]) begin
        s_next.width[c] = s_reg.wcnt[c];
        s_next.valid[c] = s_reg.pok[c] && (s_reg.wcnt[c] >= s_reg.wlim[15:0]) &&
                          (s_reg.wcnt[c] <= s_reg.wlim[31:16]);
        new_ev[c] = 1'b1;
      end
      bad_ev[c] = s_reg.valid[c] & ~s_next.valid[c];
    end

    // Error line sampling
    s_next.err_sync = {s_reg.err_sync[1:0], err_line_in};
    if (s_reg.err_sync[2] == s_reg.err_sync[1]) begin
      s_next.line = s_reg.err_sync[2];
    end

    // Speed from calibrated channels in RC mode, else from the serial speed register
    v0 = rcmix_cal(s_reg.width[0], s_reg.cal[0]);
    v1 = rcmix_cal(s_reg.width[1], s_reg.cal[1]);
    if (rc_mode) begin
      case (mix)
        MIX_LEFT: spd = rcmix_sat(36'(v0) + 36'(v1));
        MIX_RIGHT: spd = rcmix_sat(36'(v0) - 36'(v1));
        default: spd = v0;
      endcase
      used_bad = ~s_reg.valid[0] | ((mix != MIX_OFF) & ~s_reg.valid[1]);
    end else begin
      spd      = rcmix_sat(36'($signed(s_reg.ser_speed)));
      used_bad = 1'b0;
    end

    // Kill switch: only a channel not steering the motor; a lost signal counts as active
    kill_use[0] = ~rc_mode;
    kill_use[1] = ~rc_mode | (mix == MIX_OFF);
    kill = 1'b0;
    for (int c = 0; c < 2; c++) begin
      if (kill_use[c] & s_reg.ctrl[CTRL_KILL_LSB + c]) begin
        if (~s_reg.valid[c] || (c == 0 ? v0 : v1) > $signed(SPEED_MAX >> 1)) begin
          kill = 1'b1;
        end
      end
    end

    own = s_reg.ctrl[CTRL_STOP_BIT] | kill | used_bad;
    // Echo of a just-released drive lingers in the synchroniser; blank it
    // Four cycles cover three sync flops plus the line register
    s_next.oe_hist = {s_reg.oe_hist[2:0], s_reg.err_oe};

    // Own drive would read back high, so sense only while released
    ext = s_reg.ctrl[CTRL_ERRIN_BIT] & s_reg.line & ~s_reg.err_oe & ~(|s_reg.oe_hist);
    s_next.own_err = own;
    s_next.err_oe  = own;
    s_next.err_out = own;
    s_next.led     = own | s_reg.line;
    s_next.stop    = own | ext;
    s_next.speed   = s_next.stop ? '0 : spd;

    // APB: answer prepared in setup, given on first access cycle
    setup          = psel & ~penable;
    wr             = psel & penable & s_reg.pready & pwrite & ~s_reg.pslverr;
    case (paddr)
      ADDR_CTRL: rd = {{(32-CTRL_W){1'b0}}, s_reg.ctrl};
      ADDR_SPEED: rd = {16'h0000, s_reg.ser_speed};
      ADDR_CAL0: rd = s_reg.cal[0];
      ADDR_CAL1: rd = s_reg.cal[1];
      ADDR_WLIM: rd = s_reg.wlim;
      ADDR_RC0: rd = {15'h0000, s_reg.valid[0], s_reg.width[0]};
      ADDR_RC1: rd = {15'h0000, s_reg.valid[1], s_reg.width[1]};
      ADDR_STATUS: rd = {13'h0000, s_reg.line, s_reg.own_err, s_reg.stop, s_reg.speed};
      ADDR_IRQ_STAT: rd = {27'h0000000, s_reg.irq_stat};
      ADDR_IRQ_MASK: rd = {27'h0000000, s_reg.irq_mask};
      default: hit = 1'b0;
    endcase
    s_next.pready  = setup;
    s_next.prdata  = (setup & hit & ~pwrite) ? rd : '0;
    s_next.pslverr = setup & ~hit;
    if (wr) begin
      case (paddr)
        ADDR_CTRL: s_next.ctrl = CTRL_W'(rcmix_wm(32'(s_reg.ctrl), pwdata, pstrb));
        ADDR_SPEED: s_next.ser_speed = SPD_W'(rcmix_wm(32'(s_reg.ser_speed), pwdata, pstrb));
        ADDR_CAL0: s_next.cal[0] = rcmix_wm(s_reg.cal[0], pwdata, pstrb);
        ADDR_CAL1: s_next.cal[1] = rcmix_wm(s_reg.cal[1], pwdata, pstrb);
        ADDR_WLIM: s_next.wlim = rcmix_wm(s_reg.wlim, pwdata, pstrb);
        ADDR_IRQ_STAT: clr = pstrb[0] ? pwdata[IRQ_W-1:0] : '0;
        ADDR_IRQ_MASK: s_next.irq_mask = IRQ_W'(rcmix_wm(32'(s_reg.irq_mask), pwdata, pstrb));
        default: ;
      endcase
    end

    // Sticky events; a new event beats a same-cycle clear
    s_next.irq_stat = (s_reg.irq_stat & ~clr) |
                      {s_next.stop & ~s_reg.stop, bad_ev, new_ev};
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata       = s_reg.prdata;
  assign pready       = s_reg.pready;
  assign pslverr      = s_reg.pslverr;
  assign err_line_out = s_reg.err_out;
  assign err_line_oe  = s_reg.err_oe;
  assign err_led      = s_reg.led;
  assign motor_speed  = s_reg.speed;
  assign motor_stop   = s_reg.stop;
  assign irq          = s_reg.irq;

endmodule

//--- verification/rcmix_assertions.sv
// Port checker for the RC pulse mixer, bound into rcmix_core.
// Assumes the bench feeds the resolved error wire back to err_line_in.
`timescale 1ns/1ns
module rcmix_assertions
  import rcmix_pkg::*;
#(
  parameter logic [SPD_W-1:0] SPEED_MAX = SPD_W'(SPEED_MAX_DEF)
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    err_line_in,
  input wire logic                    err_line_out,
  input wire logic                    err_line_oe,
  input wire logic                    err_led,
  input wire logic signed [SPD_W-1:0] motor_speed,
  input wire logic                    motor_stop
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held past one cycle");
  err_resp_a: assert property (pslverr |-> pready) else $error("error response without ready");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  drive_high_a: assert property (err_line_oe |-> err_line_out) else $error("error line driven low");
  own_err_stop_a: assert property (err_line_oe && $past(err_line_oe) |-> motor_stop && err_led)
    else $error("driving error while running");
  shared_led_a: assert property (err_line_in [*6] |-> err_led) else $error("led off on high line");
  quiet_led_a: assert property ((!err_line_in) [*6] ##0 !err_line_oe |-> !err_led) else $error("led on with quiet line");
  stop_zero_a: assert property (motor_stop |-> motor_speed == 16'sh0) else $error("speed while stopped");
  speed_limit_a: assert property (motor_speed <= $signed(SPEED_MAX) && motor_speed >= -$signed(SPEED_MAX))
    else $error("speed beyond limit");
endmodule
bind rcmix_core rcmix_assertions #(.SPEED_MAX(SPEED_MAX)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .err_line_in(err_line_in), .err_line_out(err_line_out), .err_line_oe(err_line_oe),
  .err_led(err_led), .motor_speed(motor_speed), .motor_stop(motor_stop)
);

//--- verification/rcmix_rc_model.sv
// RC receiver model driving both channel pins.
// Assumes 250 ns ticks; widths and period come from the bench.
`timescale 1ns/1ns
module rcmix_rc_model (
  output logic           throttle_channel_in,
  output logic           steering_channel_in,
  input  wire logic [7:0] w0_ticks,
  input  wire logic [7:0] w1_ticks,
  input  wire logic [7:0] per_ticks
);
  int a;
  int b;
  initial begin
    throttle_channel_in = 1'b0;
    steering_channel_in = 1'b0;
    forever begin
      a = w0_ticks;
      b = w1_ticks;
      throttle_channel_in = 1'b1;
      steering_channel_in = 1'b1;
      fork
        #(a * 250) throttle_channel_in = 1'b0;
        #(b * 250) steering_channel_in = 1'b0;
      join
      // Lines rest low; period kept inside the accepted rate window
      #((per_ticks - (a > b ? a : b)) * 250);
    end
  end
endmodule

//--- verification/test_rc_pulse_mixing_error_line.sv
// Self-checking bench for the RC pulse mixer and shared error line.
// Assumes shortened period limits and widths rewritten to a short range.
`timescale 1ns/1ns
module test_rc_pulse_mixing_error_line;
  import rcmix_pkg::*;
  localparam int SMAX = 1000;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               ch0;
  logic               ch1;
  logic               ext_drv = 1'b0;
  logic               err_line_out;
  logic               err_line_oe;
  logic               err_led;
  logic signed [15:0] motor_speed;
  logic               motor_stop;
  logic               irq;
  logic [7:0]         w0 = 8'd24;
  logic [7:0]         w1 = 8'd24;
  logic [31:0]        rd;
  logic               re;
  int                 bad_count = 0;
  int                 num_checks = 0;
  int                 seed = 32'hd57983cb;
  // Wire pulled low unless someone drives it high
  wire                err_wire = (err_line_oe & err_line_out) | ext_drv;
  always #2 pclk = ~pclk;
  rcmix_core #(.SPEED_MAX(16'd1000), .PERIOD_MIN(20'd8), .PERIOD_MAX(20'd120)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .throttle_channel_in(ch0), .steering_channel_in(ch1), .err_line_in(err_wire), .err_line_out(err_line_out),
    .err_line_oe(err_line_oe), .err_led(err_led), .motor_speed(motor_speed), .motor_stop(motor_stop), .irq(irq)
  );
  rcmix_rc_model i_rx (.throttle_channel_in(ch0), .steering_channel_in(ch1), .w0_ticks(w0), .w1_ticks(w1),
    .per_ticks(8'd46));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic near(input logic signed [15:0] got, input int exp, input int tol);
    num_checks++;
    if ($isunknown(got) || got < exp - tol || got > exp + tol) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One idle edge first, so psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Two fresh widths on both channels
  task automatic settle();
    repeat (2) begin
      apb(1'b1, ADDR_IRQ_STAT, 32'h3);
      do apb(1'b0, ADDR_IRQ_STAT, 32'h0); while (rd[1:0] !== 2'h3);
    end
  endtask
  function automatic int sat(input int v);
    return v > SMAX ? SMAX : (v < -SMAX ? -SMAX : v);
  endfunction
  function automatic int exp_speed(input int m, input int a, input int b);
    int c0;
    int c1;
    c0 = sat((a - 24) * 64);
    c1 = sat((b - 24) * 64);
    return m == 0 ? c0 : sat(m == 1 ? c0 + c1 : c0 - c1);
  endfunction
  initial begin
    #380000;
    bad_count++;
    complete_run();
  end
  initial begin
    int m;
    int a;
    int b;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, ADDR_CAL1, 32'h0);
    chk(rd, CAL_RST);
    apb(1'b0, ADDR_WLIM, 32'h0);
    chk(rd, WLIM_RST);
    apb(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    chk(32'(re), 32'h1);
    apb(1'b1, ADDR_WLIM, 32'h0029_0006);
    apb(1'b1, ADDR_CAL0, 32'h4000_0018);
    apb(1'b1, ADDR_CAL1, 32'h4000_0018);
    apb(1'b1, ADDR_IRQ_MASK, 32'h10);
    for (int i = 0; i < 8; i++) begin
      a = (i == 6) ? 40 : (i == 7) ? 8 : 12 + $unsigned($random(seed)) % 25;
      b = (i > 5) ? 40 : 12 + $unsigned($random(seed)) % 25;
      m = (i == 6) ? 1 : (i == 7) ? 2 : i % 3;
      w0 <= 8'(a);
      w1 <= 8'(b);
      apb(1'b1, ADDR_CTRL, 32'h9 | 32'(m << 1));
      settle();
      apb(1'b0, ADDR_RC0, 32'h0);
      near(rd[15:0], a, 1);
      apb(1'b0, ADDR_RC1, 32'h0);
      near(rd[15:0], b, 1);
      near(motor_speed, exp_speed(m, a, b), 130);
      chk(32'({motor_stop, err_line_oe, err_led}), 32'h0);
    end
    apb(1'b1, ADDR_IRQ_STAT, 32'h1f);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h28);
    settle();
    chk(32'({motor_stop, err_line_oe, err_led, irq}), 32'hf);
    apb(1'b0, ADDR_RC1, 32'h0);
    near(rd[15:0], 40, 1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h10);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(32'({rd[4], irq}), 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h8);
    // Released line needs the synchroniser to drain
    repeat (8) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[18:16]), 32'h0);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(32'(rd[4]), 32'h0);
    ext_drv <= 1'b1;
    // Three-flop synchroniser, line register and output register
    repeat (8) @(posedge pclk);
    chk(32'({motor_stop, err_line_oe, err_led}), 32'h5);
    ext_drv <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(32'({motor_stop, err_led}), 32'h0);
    w0 <= 8'd44;
    apb(1'b1, ADDR_CTRL, 32'h9);
    settle();
    apb(1'b0, ADDR_RC0, 32'h0);
    chk(32'(rd[16]), 32'h0);
    chk(32'({motor_stop, err_line_oe, err_led, motor_speed}), {13'h0, 3'h7, 16'h0});
    complete_run();
  end
endmodule
